/* File: rtl/acsi_pkg.sv */
// Overview of operation
// - Internal strobe clock sources work only in zone 1; echo works in zones 1 and 2.
// - Source-synchronous output accepts any of the four input protocol values.
// - Legacy output merges output and input words into one 22-bit shifter.
// - Analog input is sampled on the rising edge of conversion start.
// - A frame begins when chip select falls; shifting starts there.
// - In legacy output mode each launch edge drives the shifter MSB onto serial output lane 0.
// - Each capture edge shifts serial input into the shifter LSB.
// - On chip select rising the shifter content is decoded as a command.
// - Nine configuration registers sit at their printed addresses.
// - The 20-bit test pattern spans low, middle and high registers.
// - Source-synchronous modes drive ready strobe as output data clock.
// - Output mode 11b is source-synchronous; 10b is refused.
// - Strobe source: 00b echo, 01b internal, 10b half, 11b quarter.
package acsi_pkg;
  // Word layout of the unified shift register
  localparam int SHR_W    = 22;
  localparam int RES_W    = 20;
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 8;
  localparam int OP_W     = 4;
  localparam int OP_LSB   = 18;
  localparam int ADDR_LSB = 8;
  localparam int PAD_W    = 2;

  // Commands
  localparam logic [OP_W-1:0] OP_NOP   = 4'h0;
  localparam logic [OP_W-1:0] OP_WRITE = 4'h1;
  localparam logic [OP_W-1:0] OP_READ  = 4'h2;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADR_POWER_DOWN = 10'h004;
  localparam logic [ADDR_W-1:0] ADR_IN_PROTO   = 10'h008;
  localparam logic [ADDR_W-1:0] ADR_OUT_PROTO  = 10'h00C;
  localparam logic [ADDR_W-1:0] ADR_WORD_CFG   = 10'h010;
  localparam logic [ADDR_W-1:0] ADR_PAT_LOW    = 10'h014;
  localparam logic [ADDR_W-1:0] ADR_PAT_MID    = 10'h015;
  localparam logic [ADDR_W-1:0] ADR_PAT_HIGH   = 10'h016;
  localparam logic [ADDR_W-1:0] ADR_OFS_CAL    = 10'h020;
  localparam logic [ADDR_W-1:0] ADR_REF_MARGIN = 10'h030;

  // Writable bit masks and reset value
  localparam logic [DATA_W-1:0] MSK_POWER_DOWN = 8'h06;
  localparam logic [DATA_W-1:0] MSK_IN_PROTO   = 8'h03;
  localparam logic [DATA_W-1:0] MSK_OUT_PROTO  = 8'hDF;
  localparam logic [DATA_W-1:0] MSK_PAT_HIGH   = 8'h0F;
  localparam logic [DATA_W-1:0] MSK_FULL       = 8'hFF;
  localparam logic [DATA_W-1:0] REG_RST        = 8'h00;

  // Field positions
  localparam int PD_ADC_BIT    = 1;
  localparam int PD_REFBUF_BIT = 2;
  localparam int CPHA_BIT      = 0;
  localparam int CPOL_BIT      = 1;
  localparam int PAT_EN_BIT    = 0;
  localparam int MODE_LSB      = 0;
  localparam int SEL_LSB       = 6;

  // Output mode and strobe source codes
  localparam logic [1:0] MODE_SYNC  = 2'b11;
  localparam logic [1:0] MODE_BAD   = 2'b10;
  localparam logic [1:0] SEL_ECHO   = 2'b00;
  localparam logic [1:0] SEL_INT    = 2'b01;
  localparam logic [1:0] SEL_INT_D2 = 2'b10;
  localparam logic [1:0] SEL_INT_D4 = 2'b11;

  // Internal oscillator half period in system clocks
  localparam int INT_HALF_CYC = 1;

  // Synchroniser reset levels: chip select idles high
  localparam logic [4:0] PIN_RST = 5'h01;
endpackage

/* File: rtl/acsi_stream_if.sv */
`timescale 1ns/1ps
interface acsi_stream_if #(
  parameter int W = 20
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* File: rtl/acsi_sync.sv */
`timescale 1ns/1ps
module acsi_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Pins in, synchronised out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // Two flip-flop chain, first stage read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

/* File: rtl/acsi_buf.sv */
`timescale 1ns/1ps
module acsi_buf #(
  parameter int W     = 20,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Fill and drain sides
  acsi_stream_if.snk up,
  acsi_stream_if.src dn
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic          ready_r;
  logic          push;
  logic          pop;

  assign push     = up.valid & ready_r;
  assign pop      = dn.ready & (count_r != '0);
  assign up.ready = ready_r;
  assign dn.valid = (count_r != '0);
  assign dn.data  = mem_r[rd_ptr_r];

  // Occupancy
  always_comb begin
    count_nxt = count_r + CW'(push) - CW'(pop);
  end

  // Pointers, count and registered ready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      ready_r <= (count_nxt != CW'(DEPTH));
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= up.data;
    end
  end
endmodule

/* File: rtl/acsi_top.sv */
`timescale 1ns/1ps
module acsi_top #(
  parameter int INT_HALF = acsi_pkg::INT_HALF_CYC,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Host serial pins
  input  wire logic                       cs_n,
  input  wire logic                       sclk,
  input  wire logic                       sdi,
  input  wire logic                       conversion_start,
  input  wire logic                       zone2_transfer,
  output logic                            serial_out_lane0,
  output logic                            serial_out_lane0_oe,
  output logic                            ready_strobe,
  // Converter side
  output logic                            sample_strobe,
  input  wire logic [acsi_pkg::RES_W-1:0] result_data,
  input  wire logic                       result_valid,
  output logic                            result_ready,
  // Power control
  output logic                            adc_power_down,
  output logic                            refbuf_power_down
);
  localparam int UW = acsi_pkg::SHR_W;
  localparam int DW = acsi_pkg::DATA_W;
  localparam int AW = acsi_pkg::ADDR_W;

  logic [4:0]    pins_s;
  logic          cs_s;
  logic          sclk_s;
  logic          sdi_s;
  logic          cnv_s;
  logic          zone2_s;
  logic          cs_d_r;
  logic          sclk_d_r;
  logic          cnv_d_r;
  logic          frame_start;
  logic          frame_end;
  logic          in_frame;
  logic          sclk_rise;
  logic          sclk_fall;
  logic          lead_edge;
  logic          trail_edge;
  logic          capture;
  logic          launch;
  logic          cnv_rise;
  logic [DW-1:0] pd_r;
  logic [DW-1:0] in_proto_r;
  logic [DW-1:0] out_proto_r;
  logic [DW-1:0] word_cfg_r;
  logic [DW-1:0] pat_low_r;
  logic [DW-1:0] pat_mid_r;
  logic [DW-1:0] pat_high_r;
  logic [DW-1:0] ofs_cal_r;
  logic [DW-1:0] ref_margin_r;
  logic [UW-1:0] ush_r;
  logic [UW-1:0] out_sh_r;
  logic [UW-1:0] load_word;
  logic          rd_pend_r;
  logic [DW-1:0] rd_data_r;
  logic [DW-1:0] rd_val;
  logic [acsi_pkg::OP_W-1:0] cmd_op;
  logic [AW-1:0] cmd_addr;
  logic [DW-1:0] cmd_data;
  logic          cmd_write;
  logic          sdo_r;
  logic          oe_r;
  logic          sample_r;
  logic          src_mode;
  logic [1:0]    strobe_sel;
  logic          echo_sel;
  logic          src_active_r;
  logic [4:0]    src_left_r;
  logic [7:0]    div_cnt_r;
  logic [7:0]    half_lim;
  logic          tick;
  logic          strobe_r;
  logic          src_launch;

  acsi_stream_if #(.W(acsi_pkg::RES_W)) up_if ();
  acsi_stream_if #(.W(acsi_pkg::RES_W)) dn_if ();

  // Pin synchronisers
  acsi_sync #(.W(5), .RST_VAL(acsi_pkg::PIN_RST)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({zone2_transfer, conversion_start, sdi, sclk, cs_n}),
    .sync_out (pins_s)
  );
  assign cs_s    = pins_s[0];
  assign sclk_s  = pins_s[1];
  assign sdi_s   = pins_s[2];
  assign cnv_s   = pins_s[3];
  assign zone2_s = pins_s[4];

  // Result buffer between converter and frame loader
  assign up_if.data  = result_data;
  assign up_if.valid = result_valid;
  assign result_ready = up_if.ready;
  acsi_buf #(.W(acsi_pkg::RES_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk (clk),
    .rst (rst),
    .up  (up_if),
    .dn  (dn_if)
  );

  // Edge history of synchronised pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_d_r   <= 1'b1;
      sclk_d_r <= 1'b0;
      cnv_d_r  <= 1'b0;
    end else begin
      cs_d_r   <= cs_s;
      sclk_d_r <= sclk_s;
      cnv_d_r  <= cnv_s;
    end
  end

  // Frame and clock edge decode per selected input protocol
  assign frame_start = cs_d_r & ~cs_s;
  assign frame_end   = ~cs_d_r & cs_s;
  assign in_frame    = ~cs_s & ~cs_d_r;
  assign sclk_rise   = in_frame & sclk_s & ~sclk_d_r;
  assign sclk_fall   = in_frame & ~sclk_s & sclk_d_r;
  assign lead_edge   = in_proto_r[acsi_pkg::CPOL_BIT] ? sclk_fall : sclk_rise;
  assign trail_edge  = in_proto_r[acsi_pkg::CPOL_BIT] ? sclk_rise : sclk_fall;
  assign capture     = in_proto_r[acsi_pkg::CPHA_BIT] ? trail_edge : lead_edge;
  assign launch      = in_proto_r[acsi_pkg::CPHA_BIT] ? lead_edge : trail_edge;
  assign cnv_rise    = cnv_s & ~cnv_d_r;

  // Mode fields; input protocol stays in force in every output mode
  assign src_mode   = (out_proto_r[acsi_pkg::MODE_LSB +: 2] == acsi_pkg::MODE_SYNC);
  assign strobe_sel = out_proto_r[acsi_pkg::SEL_LSB +: 2];
  assign echo_sel   = (strobe_sel == acsi_pkg::SEL_ECHO);

  // Word placed in the shifter at frame start
  always_comb begin
    load_word    = '0;
    dn_if.ready  = 1'b0;
    if (rd_pend_r) begin
      load_word = {{(UW - DW){1'b0}}, rd_data_r};
    end else if (word_cfg_r[acsi_pkg::PAT_EN_BIT]) begin
      load_word = {pat_high_r[3:0], pat_mid_r, pat_low_r, {acsi_pkg::PAD_W{1'b0}}};
    end else if (dn_if.valid) begin
      load_word   = {dn_if.data, {acsi_pkg::PAD_W{1'b0}}};
      dn_if.ready = frame_start;
    end
  end

  // Unified shift register: load, then capture serial input at the LSB
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ush_r <= '0;
    end else if (frame_start) begin
      ush_r <= load_word;
    end else if (capture) begin
      ush_r <= {ush_r[UW-2:0], sdi_s};
    end
  end

  // Command fields seen at chip select rising
  assign cmd_op    = ush_r[acsi_pkg::OP_LSB +: acsi_pkg::OP_W];
  assign cmd_addr  = ush_r[acsi_pkg::ADDR_LSB +: AW];
  assign cmd_data  = ush_r[DW-1:0];
  assign cmd_write = frame_end & (cmd_op == acsi_pkg::OP_WRITE);

  // Register read mux
  always_comb begin
    rd_val = '0;
    case (cmd_addr)
      acsi_pkg::ADR_POWER_DOWN: rd_val = pd_r;
      acsi_pkg::ADR_IN_PROTO:   rd_val = in_proto_r;
      acsi_pkg::ADR_OUT_PROTO:  rd_val = out_proto_r;
      acsi_pkg::ADR_WORD_CFG:   rd_val = word_cfg_r;
      acsi_pkg::ADR_PAT_LOW:    rd_val = pat_low_r;
      acsi_pkg::ADR_PAT_MID:    rd_val = pat_mid_r;
      acsi_pkg::ADR_PAT_HIGH:   rd_val = pat_high_r;
      acsi_pkg::ADR_OFS_CAL:    rd_val = ofs_cal_r;
      acsi_pkg::ADR_REF_MARGIN: rd_val = ref_margin_r;
      default:                  rd_val = '0;
    endcase
  end

  // Configuration registers, written when chip select rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_r         <= acsi_pkg::REG_RST;
      in_proto_r   <= acsi_pkg::REG_RST;
      out_proto_r  <= acsi_pkg::REG_RST;
      word_cfg_r   <= acsi_pkg::REG_RST;
      pat_low_r    <= acsi_pkg::REG_RST;
      pat_mid_r    <= acsi_pkg::REG_RST;
      pat_high_r   <= acsi_pkg::REG_RST;
      ofs_cal_r    <= acsi_pkg::REG_RST;
      ref_margin_r <= acsi_pkg::REG_RST;
    end else if (cmd_write) begin
      case (cmd_addr)
        acsi_pkg::ADR_POWER_DOWN: pd_r <= cmd_data & acsi_pkg::MSK_POWER_DOWN;
        acsi_pkg::ADR_IN_PROTO:   in_proto_r <= cmd_data & acsi_pkg::MSK_IN_PROTO;
        acsi_pkg::ADR_OUT_PROTO: begin
          if (cmd_data[acsi_pkg::MODE_LSB +: 2] != acsi_pkg::MODE_BAD) begin
            out_proto_r <= cmd_data & acsi_pkg::MSK_OUT_PROTO;
          end
        end
        acsi_pkg::ADR_WORD_CFG:   word_cfg_r <= cmd_data;
        acsi_pkg::ADR_PAT_LOW:    pat_low_r <= cmd_data;
        acsi_pkg::ADR_PAT_MID:    pat_mid_r <= cmd_data;
        acsi_pkg::ADR_PAT_HIGH:   pat_high_r <= cmd_data & acsi_pkg::MSK_PAT_HIGH;
        acsi_pkg::ADR_OFS_CAL:    ofs_cal_r <= cmd_data;
        acsi_pkg::ADR_REF_MARGIN: ref_margin_r <= cmd_data;
        default: begin
        end
      endcase
    end
  end

  // Read command: value returned in the next frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
      rd_data_r <= '0;
    end else if (frame_end && cmd_op == acsi_pkg::OP_READ) begin
      rd_pend_r <= 1'b1;
      rd_data_r <= rd_val;
    end else if (frame_start) begin
      rd_pend_r <= 1'b0;
    end
  end

  // Sample request on conversion start rising, unless powered down
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_r <= 1'b0;
    end else begin
      sample_r <= cnv_rise & ~pd_r[acsi_pkg::PD_ADC_BIT];
    end
  end

  // Strobe half period for the chosen internal source
  always_comb begin
    half_lim = 8'h00;
    unique case (strobe_sel)
      acsi_pkg::SEL_ECHO:   half_lim = 8'h00;
      acsi_pkg::SEL_INT:    half_lim = 8'(INT_HALF - 1);
      acsi_pkg::SEL_INT_D2: half_lim = 8'(2 * INT_HALF - 1);
      acsi_pkg::SEL_INT_D4: half_lim = 8'(4 * INT_HALF - 1);
    endcase
  end
  assign tick       = src_active_r & ~echo_sel & (div_cnt_r == half_lim);
  assign src_launch = src_active_r & (src_left_r != 5'h00) &
                      (echo_sel ? sclk_rise : (tick & ~strobe_r));

  // Source-synchronous engine; internal sources refused in zone 2
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_active_r <= 1'b0;
      src_left_r   <= 5'h00;
      out_sh_r     <= '0;
    end else if (frame_end) begin
      src_active_r <= 1'b0;
      src_left_r   <= 5'h00;
    end else if (frame_start) begin
      src_active_r <= src_mode & (echo_sel | ~zone2_s);
      src_left_r   <= 5'(UW);
      out_sh_r     <= load_word;
    end else if (src_launch) begin
      src_left_r <= src_left_r - 5'h01;
      out_sh_r   <= {out_sh_r[UW-2:0], 1'b0};
    end else if (src_active_r && src_left_r == 5'h00 && !strobe_r) begin
      src_active_r <= 1'b0;
    end
  end

  // Divider on the system clock standing in for the internal oscillator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= 8'h00;
    end else if (!src_active_r || tick) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  // Ready strobe: output clock in source-synchronous frames, low otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_r <= 1'b0;
    end else if (!src_active_r || frame_end) begin
      strobe_r <= 1'b0;
    end else if (echo_sel) begin
      strobe_r <= sclk_s & (src_left_r != 5'h00);
    end else if (tick && (src_left_r != 5'h00 || strobe_r)) begin
      strobe_r <= ~strobe_r;
    end
  end

  // Serial output lane 0 and its release outside frames
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdo_r <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      oe_r <= ~cs_s;
      if (frame_start) begin
        sdo_r <= load_word[UW-1];
      end else if (src_mode) begin
        if (src_launch) begin
          sdo_r <= out_sh_r[UW-1];
        end
      end else if (launch) begin
        sdo_r <= ush_r[UW-1];
      end
    end
  end

  assign serial_out_lane0    = sdo_r;
  assign serial_out_lane0_oe = oe_r;
  assign ready_strobe        = strobe_r;
  assign sample_strobe       = sample_r;
  assign adc_power_down      = pd_r[acsi_pkg::PD_ADC_BIT];
  assign refbuf_power_down   = pd_r[acsi_pkg::PD_REFBUF_BIT];

  // Checks on the serial path and configuration
  oe_release_a: assert property (@(posedge clk) disable iff (rst)
    cs_s |=> !serial_out_lane0_oe)
    else $error("lane 0 driven while deselected");
  sample_edge_a: assert property (@(posedge clk) disable iff (rst)
    (cnv_rise && !adc_power_down) |=> sample_strobe ##1 !sample_strobe)
    else $error("conversion start edge not sampled");
  shift_in_a: assert property (@(posedge clk) disable iff (rst)
    (capture && !frame_start) |=> (ush_r[0] == $past(sdi_s)) &&
                                   (ush_r[UW-1:1] == $past(ush_r[UW-2:0])))
    else $error("capture did not shift input into LSB");
  msb_launch_a: assert property (@(posedge clk) disable iff (rst)
    (launch && !src_mode && !frame_start) |=> serial_out_lane0 == $past(ush_r[UW-1]))
    else $error("launch did not drive shifter MSB");
  frame_load_a: assert property (@(posedge clk) disable iff (rst)
    frame_start |=> ush_r == $past(load_word))
    else $error("frame start did not load shifter");
  decode_write_a: assert property (@(posedge clk) disable iff (rst)
    (cmd_write && cmd_addr == acsi_pkg::ADR_OFS_CAL) |=> ofs_cal_r == $past(cmd_data))
    else $error("write command not applied at chip select rise");
  bad_mode_a: assert property (@(posedge clk) disable iff (rst)
    (cmd_write && cmd_addr == acsi_pkg::ADR_OUT_PROTO &&
     cmd_data[1:0] == acsi_pkg::MODE_BAD) |=> $stable(out_proto_r))
    else $error("invalid output mode accepted");
  zone_refuse_a: assert property (@(posedge clk) disable iff (rst)
    (frame_start && src_mode && !echo_sel && zone2_s) |=> (!ready_strobe)[*3])
    else $error("internal strobe ran in zone 2");
  echo_strobe_a: assert property (@(posedge clk) disable iff (rst)
    (src_active_r && echo_sel && src_left_r != 5'h00 && !frame_end) |=>
      ready_strobe == $past(sclk_s))
    else $error("echo strobe does not follow serial clock");
  pattern_load_a: assert property (@(posedge clk) disable iff (rst)
    (frame_start && !rd_pend_r && word_cfg_r[acsi_pkg::PAT_EN_BIT]) |=>
      ush_r[UW-1:2] == {$past(pat_high_r[3:0]), $past(pat_mid_r), $past(pat_low_r)})
    else $error("test pattern misplaced");
endmodule

/* File: testbench/acsi_host_model.sv */
`timescale 1ns/1ps
// Host controller on the serial link: capture on sclk rise, launch on fall
module acsi_host_model (
  // Clock
  input  wire logic clk,
  // Host serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic lane0,
  input  wire logic strobe
);
  // Each sclk phase lasts this many clk, above the oversampling floor
  localparam int PH = 6;

  int unsigned strobe_rises;
  logic        strobe_d;
  logic [63:0] strobe_rx;

  // Idle pins: deselected, clock parked low
  initial begin
    cs_n         = 1'b1;
    sclk         = 1'b0;
    sdi          = 1'b0;
    strobe_d     = 1'b0;
    strobe_rx    = '0;
    strobe_rises = 0;
  end

  // Counts strobe rises and takes lane 0 on each strobe fall while the frame is open
  always @(posedge clk) begin
    strobe_d <= strobe;
    if (!cs_n && strobe && !strobe_d)
      strobe_rises <= strobe_rises + 1;
    if (!cs_n && !strobe && strobe_d)
      strobe_rx <= {strobe_rx[62:0], lane0};
  end

  // One frame of n bits sent MSB first; returns what lane 0 showed
  task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    @(negedge clk);
    strobe_rises = 0;
    strobe_rx = '0;
    cs_n = 1'b0;
    repeat (PH) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      repeat (PH) @(negedge clk);
      sclk = 1'b1;
      rx = {rx[62:0], lane0};
      repeat (PH) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (PH) @(negedge clk);
    cs_n = 1'b1;
    sdi  = ~sdi;
    repeat (3 * PH) @(negedge clk);
  endtask
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the serial configuration interface
module tb;
  logic        clk;
  logic        rst;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        conversion_start;
  logic        zone2_transfer;
  logic        serial_out_lane0;
  logic        serial_out_lane0_oe;
  logic        ready_strobe;
  logic        sample_strobe;
  logic [19:0] result_data;
  logic        result_valid;
  logic        result_ready;
  logic        adc_power_down;
  logic        refbuf_power_down;
  logic [63:0] rx;
  int          n_errors;
  int          compares;
  // Lane 0 as the host sees it: inverted garbage while released
  wire         lane_seen = serial_out_lane0_oe ? serial_out_lane0 : ~serial_out_lane0;

  // Device and host
  acsi_top #(.INT_HALF(1), .BUF_DEPTH(2)) dut (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .conversion_start(conversion_start), .zone2_transfer(zone2_transfer),
    .serial_out_lane0(serial_out_lane0), .serial_out_lane0_oe(serial_out_lane0_oe),
    .ready_strobe(ready_strobe), .sample_strobe(sample_strobe),
    .result_data(result_data), .result_valid(result_valid),
    .result_ready(result_ready), .adc_power_down(adc_power_down),
    .refbuf_power_down(refbuf_power_down));
  acsi_host_model host (
    .clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .lane0(lane_seen), .strobe(ready_strobe));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares and reports
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Command word: op, address, data
  function automatic logic [63:0] cmd(input logic [3:0] op, input logic [9:0] a,
                                      input logic [7:0] d);
    return {42'h0, op, a, d};
  endfunction

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    host.frame(22, cmd(acsi_pkg::OP_WRITE, a, d), rx);
  endtask

  // Read command, then the answer arrives in the following frame
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    host.frame(22, cmd(acsi_pkg::OP_READ, a, 8'h00), rx);
    host.frame(22, cmd(acsi_pkg::OP_NOP, 10'h000, 8'h00), rx);
    chk(rx, {56'h0, e});
  endtask

  // Reset value, then a write and its masked read-back
  task automatic reg_case(input logic [9:0] a, input logic [7:0] w, input logic [7:0] m);
    rd(a, acsi_pkg::REG_RST);
    wr(a, w);
    rd(a, w & m);
  endtask

  // Converter word into the buffer, valid held until taken
  task automatic push(input logic [19:0] d);
    int k;
    k = 0;
    @(negedge clk);
    result_data  = d;
    result_valid = 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (result_ready !== 1'b1 && k < 2000);
    if (k >= 2000) n_errors++;
    @(negedge clk);
    result_valid = 1'b0;
    result_data  = ~d;
  endtask

  task automatic conv(output int cnt);
    cnt = 0;
    @(negedge clk);
    conversion_start = 1'b1;
    repeat (12) begin
      @(posedge clk);
      #1 if (sample_strobe === 1'b1) cnt++;
    end
    @(negedge clk);
    conversion_start = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  task automatic t_regs();
    int cnt;
    reg_case(acsi_pkg::ADR_IN_PROTO, 8'hFC, acsi_pkg::MSK_IN_PROTO);
    reg_case(acsi_pkg::ADR_WORD_CFG, 8'hFE, acsi_pkg::MSK_FULL);
    reg_case(acsi_pkg::ADR_PAT_LOW, 8'hA5, acsi_pkg::MSK_FULL);
    reg_case(acsi_pkg::ADR_PAT_MID, 8'h5A, acsi_pkg::MSK_FULL);
    reg_case(acsi_pkg::ADR_PAT_HIGH, 8'hFF, acsi_pkg::MSK_PAT_HIGH);
    reg_case(acsi_pkg::ADR_OFS_CAL, 8'hC3, acsi_pkg::MSK_FULL);
    reg_case(acsi_pkg::ADR_REF_MARGIN, 8'h3C, acsi_pkg::MSK_FULL);
    reg_case(acsi_pkg::ADR_OUT_PROTO, 8'hDC, acsi_pkg::MSK_OUT_PROTO);
    wr(acsi_pkg::ADR_OUT_PROTO, 8'h02);
    rd(acsi_pkg::ADR_OUT_PROTO, 8'hDC);
    wr(acsi_pkg::ADR_OUT_PROTO, 8'h00);
    wr(10'h3FF, 8'hFF);
    rd(10'h3FF, 8'h00);
    reg_case(acsi_pkg::ADR_POWER_DOWN, 8'hFF, acsi_pkg::MSK_POWER_DOWN);
    chk({adc_power_down, refbuf_power_down}, 2'b11);
    conv(cnt);
    chk(cnt, 0);
    wr(acsi_pkg::ADR_POWER_DOWN, 8'h00);
    chk({adc_power_down, refbuf_power_down}, 2'b00);
    conv(cnt);
    chk(cnt, 1);
  endtask

  // Fill until refused, then drain with a stalled word waiting
  task automatic t_buffer();
    push(20'hABCDE);
    push(20'h12345);
    @(negedge clk);
    chk(result_ready, 1'b0);
    fork
      push(20'h0F0F0);
      host.frame(22, 64'h0, rx);
      begin
        repeat (20) @(negedge clk);
        chk(serial_out_lane0_oe, 1'b1);
      end
    join
    chk(rx, {20'hABCDE, 2'b00});
    host.frame(22, 64'h0, rx);
    chk(rx, {20'h12345, 2'b00});
    host.frame(22, 64'h0, rx);
    chk(rx, {20'h0F0F0, 2'b00});
    host.frame(22, 64'h0, rx);
    chk(rx, 64'h0);
  endtask

  // Pattern wins over a waiting converter word
  task automatic t_pattern();
    wr(acsi_pkg::ADR_PAT_LOW, 8'h34);
    wr(acsi_pkg::ADR_PAT_MID, 8'h12);
    wr(acsi_pkg::ADR_PAT_HIGH, 8'hFA);
    wr(acsi_pkg::ADR_WORD_CFG, 8'h01);
    push(20'h55555);
    wr(acsi_pkg::ADR_WORD_CFG, 8'h00);
    chk(rx, {4'hA, 8'h12, 8'h34, 2'b00});
    host.frame(22, 64'h0, rx);
    chk(rx, {20'h55555, 2'b00});
  endtask

  // Two-word frame: first word passes through, last word decodes
  task automatic t_chain();
    host.frame(44, {cmd(acsi_pkg::OP_NOP, 10'h2AA, 8'h55), 22'h0}
                   | cmd(acsi_pkg::OP_WRITE, acsi_pkg::ADR_OFS_CAL, 8'h77), rx);
    chk(rx, cmd(acsi_pkg::OP_NOP, 10'h2AA, 8'h55));
    rd(acsi_pkg::ADR_OFS_CAL, 8'h77);
    wr(acsi_pkg::ADR_IN_PROTO, 8'h03);
    rd(acsi_pkg::ADR_IN_PROTO, 8'h03);
    wr(acsi_pkg::ADR_IN_PROTO, 8'h00);
  endtask

  // Strobe sources, zone limits and the return to legacy output
  task automatic t_src();
    logic [63:0] pat;
    pat = {42'h0, 4'hA, 8'h12, 8'h34, 2'b00};
    wr(acsi_pkg::ADR_WORD_CFG, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(acsi_pkg::ADR_OUT_PROTO, {s[1:0], 6'h03});
      host.frame(22, 64'h0, rx);
      chk(host.strobe_rises, 22);
      chk(host.strobe_rx, pat);
    end
    wr(acsi_pkg::ADR_OUT_PROTO, 8'h43);
    zone2_transfer = 1'b1;
    host.frame(22, 64'h0, rx);
    chk(host.strobe_rises, 0);
    wr(acsi_pkg::ADR_OUT_PROTO, 8'h03);
    host.frame(22, 64'h0, rx);
    chk(host.strobe_rises, 22);
    chk(host.strobe_rx, pat);
    zone2_transfer = 1'b0;
    wr(acsi_pkg::ADR_OUT_PROTO, 8'h00);
    rd(acsi_pkg::ADR_OUT_PROTO, 8'h00);
    chk(host.strobe_rises, 0);
  endtask

  // Watchdog
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    compares = 0;
    rst = 1'b1;
    conversion_start = 1'b0;
    zone2_transfer = 1'b0;
    result_data = 20'h00000;
    result_valid = 1'b0;
    repeat (2) @(negedge clk);
    chk(result_ready, 1'b0);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk({result_ready, serial_out_lane0_oe, ready_strobe}, 3'b100);
    t_regs();
    t_buffer();
    t_pattern();
    t_chain();
    t_src();
    chk(serial_out_lane0_oe, 1'b0);
    close_out();
  end
endmodule
